// ---- sdc_cfg.svh ----
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ==========================================================
// Register byte offsets
`define SDC_OFS_GEOM        8'h08
`define SDC_OFS_LPWR        8'h10
`define SDC_OFS_IRQ_SET     8'h14
`define SDC_OFS_IRQ_CLR     8'h18
`define SDC_OFS_IRQ_MASK    8'h1c
`define SDC_OFS_STATUS      8'h20

// ==========================================================
// Reset values
`define SDC_GEOM_RST        32'h852372c0
`define SDC_LPWR_RST        32'h00000000

// ==========================================================
// Geometry and timing field positions (lsb)
`define SDC_F_COLS          0
`define SDC_F_ROWS          2
`define SDC_F_BANKS         4
`define SDC_F_CAS           5
`define SDC_F_WIDTH         7
`define SDC_F_TWR           8
`define SDC_F_TRC           12
`define SDC_F_TRP           16
`define SDC_F_ACTIVATE_TO_ACCESS_CYCLES          20
`define SDC_F_ACTIVATE_TO_PRECHARGE_CYCLES          24
`define SDC_F_SELF_REFRESH_EXIT_CYCLES          28

// ==========================================================
// Low-power field positions (lsb)
`define SDC_F_LPSEL         0
`define SDC_F_PARTIAL_ARRAY_SELECT          4
`define SDC_F_TEMP_COMP_REFRESH          8
`define SDC_F_DS            10
`define SDC_F_TMO           12

// ==========================================================
// Idle timeouts in master clock cycles
`define SDC_TMO_SHORT       8'd64
`define SDC_TMO_LONG        8'd128

// ==========================================================
// Bus answers
`define SDC_RESP_OKAY       2'h0
`define SDC_RESP_SLVERR     2'h2

`endif

// ---- sdc_pkg.sv ----
// ==========================================================
// Types shared by the controller files
package sdc_pkg;

  typedef enum logic [3:0] {
    SDC_IDLE  = 4'h0,
    SDC_RCD   = 4'h1,
    SDC_RAS   = 4'h3,
    SDC_RP    = 4'h2,
    SDC_TRC   = 4'h6,
    SDC_SREF  = 4'h4,
    SDC_SELF_REFRESH_EXIT_CYCLES  = 4'h5,
    SDC_PDOWN = 4'hc,
    SDC_DEEP  = 4'hd
  } sdc_state_t;

  typedef enum logic [3:0] {
    SDC_CMD_NOP  = 4'h0,
    SDC_CMD_ACT  = 4'h1,
    SDC_CMD_RD   = 4'h2,
    SDC_CMD_WR   = 4'h3,
    SDC_CMD_PRE  = 4'h4,
    SDC_CMD_REF  = 4'h5,
    SDC_CMD_EMRS = 4'h6,
    SDC_CMD_SREF = 4'h7,
    SDC_CMD_PDN  = 4'h8,
    SDC_CMD_DPD  = 4'h9
  } sdc_cmd_t;

  typedef enum logic [1:0] {
    SDC_LP_OFF  = 2'h0,
    SDC_LP_SELF = 2'h1,
    SDC_LP_PDN  = 2'h2,
    SDC_LP_DEEP = 2'h3
  } sdc_lp_t;

endpackage : sdc_pkg

// ---- sdc_sync3.sv ----
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Three-stage synchroniser; output moves once stages two and three agree
module sdc_sync3 (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic din,
  output var  logic dout
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic q_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Agreement filter rejects a single metastable resolution
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      q_ff <= s3_ff;
    end
  end

  assign dout = q_ff;

endmodule : sdc_sync3

`default_nettype wire

// ---- sdc_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "sdc_cfg.svh"

module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int IDLE_CW = 8
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output var  logic                s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output var  logic                s_axi_wready,
  output var  logic [1:0]          s_axi_bresp,
  output var  logic                s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output var  logic                s_axi_arready,
  output var  logic [31:0]         s_axi_rdata,
  output var  logic [1:0]          s_axi_rresp,
  output var  logic                s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Access and maintenance requests
  input  wire logic                acc_req,
  input  wire logic                acc_write,
  output var  logic                acc_grant,
  input  wire logic                refresh_req,
  input  wire logic                init_emrs_req,
  input  wire logic                refresh_fault,
  // Memory side
  input  wire logic                link_clk,
  output var  logic [3:0]          mem_cmd,
  output var  logic [6:0]          emr_value,
  output var  logic                mem_clock_enable,
  output var  logic                mem_clock_out,
  // Decoded geometry and interrupt
  output var  logic [3:0]          col_bits,
  output var  logic [3:0]          row_bits,
  output var  logic [2:0]          bank_count,
  output var  logic [1:0]          cas_latency,
  output var  logic                bus_width_16,
  output var  logic                irq
);

  if (ADDR_W < 8 || IDLE_CW < 8) begin : g_bad_param
    $error("sdc_ctrl: ADDR_W and IDLE_CW must be at least 8");
  end

  // ========================================================
  // Register state
  logic [31:0]       geom_ff;
  logic [31:0]       lpwr_ff;
  logic              mask_ff;
  logic              fault_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              aw_have_ff;
  logic              w_have_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  logic [3:0] write_recovery_cycles;
  logic [3:0] refresh_to_activate_cycles;
  logic [3:0] precharge_wait_cycles;
  logic [3:0] activate_to_access_cycles;
  logic [3:0] activate_to_precharge_cycles;
  logic [3:0] self_refresh_exit_cycles;
  sdc_lp_t    low_power_select;
  logic [2:0] partial_array_select;
  logic [1:0] temp_comp_refresh;
  logic [1:0] output_drive_select;
  logic [1:0] idle_tmo_sel;
  logic [6:0] ext_fields;

  assign write_recovery_cycles        = geom_ff[`SDC_F_TWR  +: 4];
  assign refresh_to_activate_cycles   = geom_ff[`SDC_F_TRC  +: 4];
  assign precharge_wait_cycles        = geom_ff[`SDC_F_TRP  +: 4];
  assign activate_to_access_cycles    = geom_ff[`SDC_F_ACTIVATE_TO_ACCESS_CYCLES +: 4];
  assign activate_to_precharge_cycles = geom_ff[`SDC_F_ACTIVATE_TO_PRECHARGE_CYCLES +: 4];
  assign self_refresh_exit_cycles     = geom_ff[`SDC_F_SELF_REFRESH_EXIT_CYCLES +: 4];
  assign low_power_select             = sdc_lp_t'(lpwr_ff[`SDC_F_LPSEL +: 2]);
  assign partial_array_select         = lpwr_ff[`SDC_F_PARTIAL_ARRAY_SELECT +: 3];
  assign temp_comp_refresh            = lpwr_ff[`SDC_F_TEMP_COMP_REFRESH +: 2];
  assign output_drive_select          = lpwr_ff[`SDC_F_DS   +: 2];
  assign idle_tmo_sel                 = lpwr_ff[`SDC_F_TMO  +: 2];
  assign ext_fields = {output_drive_select, temp_comp_refresh, partial_array_select};

  function automatic logic [31:0] sdc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : sdc_merge

  // ========================================================
  // AXI4-Lite write channel
  logic wr_fire;
  logic ar_fire;
  logic rd_status;

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign wr_fire       = aw_have_ff && w_have_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `SDC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_have_ff <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_have_ff <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_ff <= 1'b0;
        w_have_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        unique case (awaddr_ff[7:0])
          `SDC_OFS_GEOM, `SDC_OFS_LPWR, `SDC_OFS_IRQ_SET,
          `SDC_OFS_IRQ_CLR: bresp_ff <= `SDC_RESP_OKAY;
          default:          bresp_ff <= `SDC_RESP_SLVERR;
        endcase
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ========================================================
  // Configuration registers and interrupt mask
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      geom_ff <= `SDC_GEOM_RST;
      lpwr_ff <= `SDC_LPWR_RST;
      mask_ff <= 1'b0;
    end else if (wr_fire && (awaddr_ff >> 8) == '0) begin
      unique case (awaddr_ff[7:0])
        `SDC_OFS_GEOM: geom_ff <= sdc_merge(geom_ff, wdata_ff, wstrb_ff);
        `SDC_OFS_LPWR: lpwr_ff <= sdc_merge(lpwr_ff, wdata_ff, wstrb_ff);
        `SDC_OFS_IRQ_SET: begin
          if (wstrb_ff[0] && wdata_ff[0]) begin
            mask_ff <= 1'b1;
          end
        end
        `SDC_OFS_IRQ_CLR: begin
          if (wstrb_ff[0] && wdata_ff[0]) begin
            mask_ff <= 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // ========================================================
  // AXI4-Lite read channel
  assign s_axi_arready = !rvalid_ff;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_status     = ar_fire && s_axi_araddr == ADDR_W'(`SDC_OFS_STATUS);
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `SDC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `SDC_RESP_OKAY;
      rdata_ff  <= 32'h00000000;
      if ((s_axi_araddr >> 8) != '0) begin
        rresp_ff <= `SDC_RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr[7:0])
          `SDC_OFS_GEOM:     rdata_ff <= geom_ff;
          `SDC_OFS_LPWR:     rdata_ff <= lpwr_ff;
          `SDC_OFS_IRQ_SET, `SDC_OFS_IRQ_CLR: rdata_ff <= 32'h00000000;
          `SDC_OFS_IRQ_MASK: rdata_ff <= {31'h0, mask_ff};
          `SDC_OFS_STATUS:   rdata_ff <= {31'h0, fault_ff};
          default:           rresp_ff <= `SDC_RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ========================================================
  // Refresh error status, cleared by reading it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
    end else if (refresh_fault) begin
      fault_ff <= 1'b1;
    end else if (rd_status) begin
      fault_ff <= 1'b0;
    end
  end

  assign irq = fault_ff && mask_ff;

  // ========================================================
  // Geometry decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      col_bits     <= 4'h8;
      row_bits     <= 4'hb;
      bank_count   <= 3'h2;
      cas_latency  <= 2'h2;
      bus_width_16 <= 1'b1;
    end else begin
      col_bits     <= 4'h8 + {2'h0, geom_ff[`SDC_F_COLS +: 2]};
      // Reserved row code clamps to the widest legal row
      row_bits     <= (geom_ff[`SDC_F_ROWS +: 2] == 2'h3) ? 4'hd
                    : 4'hb + {2'h0, geom_ff[`SDC_F_ROWS +: 2]};
      bank_count   <= geom_ff[`SDC_F_BANKS] ? 3'h4 : 3'h2;
      cas_latency  <= geom_ff[`SDC_F_CAS +: 2];
      bus_width_16 <= geom_ff[`SDC_F_WIDTH];
    end
  end

  // ========================================================
  // Pending maintenance requests, set wins over service
  logic       ref_pend_ff;
  logic       init_pend_ff;
  logic       ref_take;
  logic       init_take;
  sdc_state_t state_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ref_pend_ff  <= 1'b0;
      init_pend_ff <= 1'b0;
    end else begin
      ref_pend_ff  <= refresh_req || (ref_pend_ff && !ref_take);
      init_pend_ff <= init_emrs_req || (init_pend_ff && !init_take);
    end
  end

  // ========================================================
  // Idle timer before low-power entry
  logic [IDLE_CW-1:0] idle_cnt_ff;
  logic               tmo_hit;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt_ff <= '0;
    end else if (state_ff != SDC_IDLE || acc_req) begin
      idle_cnt_ff <= '0;
    end else if (idle_cnt_ff != '1) begin
      idle_cnt_ff <= IDLE_CW'(idle_cnt_ff + 1'b1);
    end
  end

  always_comb begin
    unique case (idle_tmo_sel)
      2'h0:    tmo_hit = 1'b1;
      2'h1:    tmo_hit = idle_cnt_ff >= IDLE_CW'(`SDC_TMO_SHORT);
      2'h2:    tmo_hit = idle_cnt_ff >= IDLE_CW'(`SDC_TMO_LONG);
      default: tmo_hit = 1'b0;
    endcase
  end

  // ========================================================
  // Link clock sampled into the master domain
  logic link_lvl;

  sdc_sync3 u_link_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (link_clk),
    .dout  (link_lvl)
  );

  // ========================================================
  // Command sequencer
  logic [3:0] wait_ff;
  logic [3:0] ras_ff;
  logic       wr_ff;
  logic       clk_run_ff;
  logic [6:0] emr_shadow_ff;
  logic       lp_go;

  // holds here: code 00 never reaches the low-power branch
  assign lp_go     = low_power_select != SDC_LP_OFF && tmo_hit && !acc_req
                     && !ref_pend_ff && !init_pend_ff;
  assign ref_take  = state_ff == SDC_IDLE && ref_pend_ff;
  assign init_take = state_ff == SDC_IDLE && !ref_pend_ff && init_pend_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= SDC_IDLE;
      mem_cmd          <= SDC_CMD_NOP;
      wait_ff          <= 4'h0;
      ras_ff           <= 4'h0;
      wr_ff            <= 1'b0;
      acc_grant        <= 1'b0;
      mem_clock_enable <= 1'b1;
      clk_run_ff       <= 1'b1;
      emr_shadow_ff    <= 7'h00;
      emr_value        <= 7'h00;
    end else begin
      mem_cmd   <= SDC_CMD_NOP;
      acc_grant <= 1'b0;
      if (ras_ff != 4'h0) begin
        ras_ff <= ras_ff - 4'h1;
      end
      if (wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end
      unique case (state_ff)
        SDC_IDLE: begin
          if (ref_pend_ff) begin
            mem_cmd  <= SDC_CMD_REF;
            wait_ff  <= refresh_to_activate_cycles;
            state_ff <= SDC_TRC;
          end else if (init_pend_ff) begin
            mem_cmd       <= SDC_CMD_EMRS;
            emr_value     <= ext_fields;
            emr_shadow_ff <= ext_fields;
          end else if (acc_req) begin
            mem_cmd  <= SDC_CMD_ACT;
            wr_ff    <= acc_write;
            wait_ff  <= activate_to_access_cycles;
            ras_ff   <= activate_to_precharge_cycles;
            state_ff <= SDC_RCD;
          end else if (lp_go) begin
            unique case (low_power_select)
              SDC_LP_SELF: begin
                if (ext_fields != emr_shadow_ff) begin
                  mem_cmd       <= SDC_CMD_EMRS;
                  emr_value     <= ext_fields;
                  emr_shadow_ff <= ext_fields;
                end else begin
                  mem_cmd          <= SDC_CMD_SREF;
                  mem_clock_enable <= 1'b0;
                  clk_run_ff       <= 1'b0;
                  state_ff         <= SDC_SREF;
                end
              end
              SDC_LP_PDN: begin
                mem_cmd          <= SDC_CMD_PDN;
                mem_clock_enable <= 1'b0;
                state_ff         <= SDC_PDOWN;
              end
              default: begin
                mem_cmd          <= SDC_CMD_DPD;
                mem_clock_enable <= 1'b0;
                clk_run_ff       <= 1'b0;
                state_ff         <= SDC_DEEP;
              end
            endcase
          end
        end
        SDC_RCD: begin
          if (wait_ff == 4'h0) begin
            mem_cmd   <= wr_ff ? SDC_CMD_WR : SDC_CMD_RD;
            acc_grant <= 1'b1;
            wait_ff   <= wr_ff ? write_recovery_cycles : 4'h0;
            state_ff  <= SDC_RAS;
          end
        end
        SDC_RAS: begin
          if (wait_ff == 4'h0 && ras_ff == 4'h0) begin
            mem_cmd  <= SDC_CMD_PRE;
            wait_ff  <= precharge_wait_cycles;
            state_ff <= SDC_RP;
          end
        end
        SDC_RP, SDC_TRC, SDC_SELF_REFRESH_EXIT_CYCLES: begin
          // Each wait ends back in idle before any new command
          if (wait_ff == 4'h0) begin
            state_ff <= SDC_IDLE;
          end
        end
        SDC_SREF: begin
          // Device refreshes itself; exit only for access or mode change
          if (acc_req || low_power_select != SDC_LP_SELF) begin
            mem_clock_enable <= 1'b1;
            clk_run_ff       <= 1'b1;
            wait_ff          <= self_refresh_exit_cycles;
            state_ff         <= SDC_SELF_REFRESH_EXIT_CYCLES;
          end
        end
        SDC_PDOWN: begin
          if (acc_req || ref_pend_ff || low_power_select != SDC_LP_PDN) begin
            mem_clock_enable <= 1'b1;
            state_ff         <= SDC_IDLE;
          end
        end
        SDC_DEEP: begin
          // Contents are lost; software must re-initialise before use
          if (low_power_select != SDC_LP_DEEP) begin
            mem_clock_enable <= 1'b1;
            clk_run_ff       <= 1'b1;
            state_ff         <= SDC_IDLE;
          end
        end
        default: state_ff <= SDC_IDLE;
      endcase
    end
  end

  // ========================================================
  // Memory clock, gated while self-refresh or deep power-down
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_clock_out <= 1'b0;
    end else begin
      mem_clock_out <= link_lvl && clk_run_ff;
    end
  end

endmodule : sdc_ctrl

`default_nettype wire

// ---- sdc_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// Port checks
module sdc_chk import sdc_pkg::*; (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       acc_grant,
  input wire logic       mem_clock_enable,
  input wire logic       irq,
  input wire logic       refresh_fault,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [3:0] mem_cmd
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_act;
    mem_cmd == SDC_CMD_ACT;
  endsequence
  sequence s_no_pre;
    mem_cmd inside {SDC_CMD_NOP, SDC_CMD_RD, SDC_CMD_WR};
  endsequence
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("late write answer");
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bh: assert property (p_bh) else $error("answer dropped");
  property p_gnt; acc_grant |-> mem_cmd inside {SDC_CMD_RD, SDC_CMD_WR} ##1 !acc_grant; endproperty
  a_gnt: assert property (p_gnt) else $error("grant without access");
  property p_pre; mem_cmd == SDC_CMD_PRE |=> mem_cmd == SDC_CMD_NOP; endproperty
  a_pre: assert property (p_pre) else $error("command after precharge");
  property p_ras; s_act |=> s_no_pre; endproperty
  a_ras: assert property (p_ras) else $error("row closed early");
  property p_srf; mem_cmd == SDC_CMD_SREF |=> !mem_clock_enable; endproperty
  a_srf: assert property (p_srf) else $error("clock enable high in self refresh");
  property p_pdn; mem_cmd == SDC_CMD_PDN |=> !mem_clock_enable; endproperty
  a_pdn: assert property (p_pdn) else $error("clock enable high in power down");
  property p_irq; $rose(irq) |-> $past(refresh_fault) || $rose(s_axi_bvalid); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule : sdc_chk
bind sdc_ctrl sdc_chk u_chk (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .acc_grant, .mem_clock_enable, .irq,
  .refresh_fault, .s_axi_bresp, .mem_cmd);
`default_nettype wire

// ---- sdc_mem.sv ----
`timescale 1ns/100ps
`default_nettype none
// ====
// Memory device model
module sdc_mem import sdc_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       mem_clock_enable,
  input  wire logic [3:0] mem_cmd,
  input  wire logic [6:0] emr_value,
  output var  logic       link_clk,
  output var  logic       in_self_ff
);
  logic [2:0] part_ff;
  initial link_clk = 1'h0;
  // Free running source, unrelated to mclk
  always #24 link_clk = ~link_clk;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) in_self_ff <= 1'h0;
    else if (mem_cmd == SDC_CMD_SREF) in_self_ff <= 1'h1;
    else if (mem_clock_enable) in_self_ff <= 1'h0;
  end
  // Only these banks keep data in self refresh
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) part_ff <= 3'h0;
    else if (mem_cmd == SDC_CMD_EMRS) part_ff <= emr_value[2:0];
  end
endmodule : sdc_mem
`default_nettype wire

// ---- sdram_ctrl_config_lowpower_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module sdram_ctrl_config_lowpower_tb import sdc_pkg::*;;
  logic        mclk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cke_q = 1'h0;
  logic        acc_req = 1'h0, acc_write = 1'h0, refresh_req = 1'h0;
  logic        init_emrs_req = 1'h0, refresh_fault = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, g, v;
  logic [3:0]  s_axi_wstrb = 4'hf, mem_cmd, col_bits, row_bits;
  logic [1:0]  s_axi_bresp, s_axi_rresp, cas_latency, rsp;
  logic [2:0]  bank_count;
  logic [6:0]  emr_value;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        acc_grant, mem_clock_enable, mem_clock_out, bus_width_16, irq, link_clk, in_self;
  int          fails = 0, n_compared = 0, cyc = 0, tr = 0, w, s0, e0;
  int          tc[16], nc[16];
  int          lp[6] = '{32'h2, 32'h1002, 32'h2002, 32'hd51, 32'h0, 32'h3};

  sdc_ctrl DUT (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .acc_req, .acc_write, .acc_grant, .refresh_req, .init_emrs_req,
    .refresh_fault, .link_clk, .mem_cmd, .emr_value, .mem_clock_enable, .mem_clock_out,
    .col_bits, .row_bits, .bank_count, .cas_latency, .bus_width_16, .irq);
  sdc_mem u_mem (.mclk, .rst_n, .mem_clock_enable, .mem_cmd, .emr_value, .link_clk,
    .in_self_ff(in_self));

  always #2.5 mclk = ~mclk;
  // ====
  // Command log: last cycle and count per command
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    cke_q <= mem_clock_enable;
    if (mem_clock_enable && !cke_q) tr <= cyc;
    if (mem_cmd != 4'h0) begin
      tc[mem_cmd] <= cyc;
      nc[mem_cmd] <= nc[mem_cmd] + 1;
    end
  end

  function logic [13:0] dec(input logic [31:0] c);
    dec = {4'h8 + c[1:0], 4'hb + c[3:2], c[4] ? 3'h4 : 3'h2, c[6:5], c[7]};
  endfunction : dec

  task ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : ck

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, b;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge mclk);
      ah = s_axi_awready;
      wh = s_axi_wready;
      b = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge mclk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
    end while (!b);
    s_axi_bready <= 1'h0;
  endtask : wr

  task rd(input logic [7:0] a);
    logic ar, r;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge mclk);
      ar = s_axi_arready;
      r = s_axi_rvalid;
      v = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge mclk);
      if (ar) s_axi_arvalid <= 1'h0;
    end while (!r);
    s_axi_rready <= 1'h0;
  endtask : rd

  task acc;
    logic gr;
    @(posedge mclk);
    acc_req <= 1'h1;
    acc_write <= 1'($urandom);
    do begin
      @(negedge mclk);
      gr = acc_grant;
      @(posedge mclk);
    end while (!gr);
    acc_req <= 1'h0;
  endtask : acc

  task wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    wrap_up;
  end

  initial begin
    v = $urandom(32'h2bda5ea0);
    repeat (10) @(posedge mclk);
    rst_n <= 1'h1;
    rd(8'h08);
    ck(v, 32'h852372c0);
    ck({col_bits, row_bits, bank_count, cas_latency, bus_width_16}, dec(32'h852372c0));
    rd(8'h40);
    ck(rsp, 2'h2);
    wr(8'h40, 32'h0);
    ck(rsp, 2'h2);
    // First pass has every timing count at zero
    for (int i = 0; i < 6; i++) begin
      g = (i == 0) ? 32'h20 : $urandom;
      if (g[3:2] == 2'h3) g[3] = 1'h0;
      if (g[6:5] == 2'h0) g[5] = 1'h1;
      wr(8'h08, g);
      rd(8'h08);
      ck(v, g);
      ck({col_bits, row_bits, bank_count, cas_latency, bus_width_16}, dec(g));
      refresh_req <= 1'h1;
      @(posedge mclk) refresh_req <= 1'h0;
      acc;
      repeat (40) @(posedge mclk);
      w = (tc[2] > tc[3]) ? tc[2] : tc[3];
      ck(w - tc[1], g[23:20] + 1);
      ck(tc[4] - tc[1] >= g[27:24], 1);
      if (acc_write) ck(tc[4] - w > g[11:8], 1);
      ck(tc[1] - tc[5] > g[15:12], 1);
    end
    wr(8'h14, 32'h0);
    rd(8'h1c);
    ck(v, 32'h0);
    wr(8'h14, 32'h1);
    rd(8'h1c);
    ck(v, 32'h1);
    refresh_fault <= 1'h1;
    @(posedge mclk) refresh_fault <= 1'h0;
    @(negedge mclk) ck(irq, 1'h1);
    rd(8'h20);
    ck(v[0], 1'h1);
    rd(8'h20);
    ck(v[0], 1'h0);
    wr(8'h18, 32'h1);
    rd(8'h1c);
    ck(v, 32'h0);
    wr(8'h10, 32'h350);
    init_emrs_req <= 1'h1;
    @(posedge mclk) init_emrs_req <= 1'h0;
    repeat (20) @(posedge mclk);
    ck(emr_value, 7'h1d);
    for (int i = 0; i < 6; i++) begin
      s0 = nc[7] + nc[8] + nc[9];
      e0 = nc[6 + lp[i][1:0]];
      wr(8'h10, lp[i]);
      if (i < 5) acc;
      repeat (200) @(posedge mclk);
      if (lp[i][1:0] == 2'h0) ck(nc[7] + nc[8] + nc[9], s0);
      else ck(nc[6 + lp[i][1:0]] > e0, 1);
      if (i < 3) ck(tc[8] - tc[4] >= 64 * lp[i][13:12], 1);
      if (i == 3) ck({emr_value, mem_clock_out, in_self}, {7'h6d, 2'h1});
      if (i == 3) ck(u_mem.part_ff, 3'h5);
      if (i == 4) ck(tc[1] - tr >= g[31:28], 1);
    end
    wrap_up;
  end
endmodule : sdram_ctrl_config_lowpower_tb
`default_nettype wire
